// >>> hdl/lut_cfg.svh
// Purpose: offsets, field positions, reset values, timing for the lookup table
// Assumes: 25 MHz pclk, 32-bit apb data
// Notes: definitions only
`ifndef LUT_CFG_SVH
`define LUT_CFG_SVH

// word indices inside the misc region, and region codes of the point arrays
`define LUT_ADDR_CTRL 4'h0
`define LUT_ADDR_STATUS 4'h1
`define LUT_ADDR_OUT 4'h2
`define LUT_ADDR_LIMITS 4'h3
`define LUT_ADDR_THRESH 4'h4
`define LUT_REG_X 2'h1
`define LUT_REG_Y 2'h2
`define LUT_REG_RESP 2'h3

// ctrl fields and reset values
`define LUT_CTRL_TIME 0
`define LUT_CTRL_DIGITAL 1
`define LUT_CTRL_RST 2'h0
`define LUT_THRESH_RST 32'h00000001

// table shape
`define LUT_LAST 4'hA

// timing: 1 ms tick from a 40 ns clock
`define LUT_CLK_NS 40
`define LUT_TICK_MS 1
`define LUT_TICK_CYCLES ((`LUT_TICK_MS * 1000000) / `LUT_CLK_NS)
`define LUT_MAX_IVAL_MS 32'h05265C00
`define LUT_DIV_STEPS 6'h31

`endif

// >>> hdl/lut_pkg.sv
// Purpose: shared types of the lookup table block
// Assumes: nothing beyond the cfg header
// Notes: carries enums and structs only
package lut_pkg;

    // per-point response encoding
    typedef enum logic [1:0] {
        lut_ignore = 2'h0,
        lut_ramp = 2'h1,
        lut_step = 2'h2
    } lut_resp_type;

    // evaluation states, gray along idle-wait
    typedef enum logic [1:0] {
        lut_idle = 2'h0,
        lut_wait = 2'h1
    } lut_state_type;

    // table output limits
    typedef struct packed {
        logic signed [15:0] hi;
        logic signed [15:0] lo;
    } lut_limits_type;

    // divide request: magnitude of dy times offset over span
    typedef struct packed {
        logic [48:0] num;
        logic [32:0] den;
    } lut_div_req_type;

endpackage : lut_pkg

// >>> hdl/lut_divider.sv
// Purpose: restoring unsigned divider for segment interpolation
// Assumes: quotient fits 16 bits (offset never above span)
// Notes: a new start reloads even while busy
`timescale 1ns/1ps
`default_nettype none
`include "lut_cfg.svh"

module lut_divider (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request
    input wire logic start,
    input wire lut_pkg::lut_div_req_type req,
    // result
    output logic done,
    output logic [15:0] quo
);

    logic [48:0] q_q;
    logic [48:0] num_q;
    logic [33:0] r_q;
    logic [32:0] den_q;
    logic [5:0] cnt_q;
    logic busy_q;
    logic done_q;

    // one quotient bit per cycle
    wire [33:0] r_sh = {r_q[32:0], q_q[48]};
    wire fits = r_sh >= {1'b0, den_q};
    wire [33:0] r_nx = fits ? r_sh - {1'b0, den_q} : r_sh;

    // shift/subtract sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_q <= 49'h0;
            num_q <= 49'h0;
            r_q <= 34'h0;
            den_q <= 33'h0;
            cnt_q <= 6'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (start) begin
            q_q <= req.num;
            num_q <= req.num;
            r_q <= 34'h0;
            den_q <= req.den;
            cnt_q <= `LUT_DIV_STEPS;
            busy_q <= 1'b1;
            done_q <= 1'b0;
        end else if (busy_q) begin
            q_q <= {q_q[47:0], fits};
            r_q <= r_nx;
            cnt_q <= cnt_q - 6'h1;
            busy_q <= cnt_q != 6'h1;
            done_q <= cnt_q == 6'h1;
        end else begin
            done_q <= 1'b0;
        end
    end

    assign done = done_q;
    assign quo = q_q[15:0];

    a_div_exact: assert property (@(posedge pclk) disable iff (!presetn)
        done_q |-> ({33'h0, q_q} * {49'h0, den_q} + {48'h0, r_q}) == {33'h0, num_q})
        else $error("divider result inconsistent");

endmodule : lut_divider
`default_nettype wire

// >>> hdl/lut_ms_tick.sv
// Purpose: millisecond time base for the time profile
// Assumes: ticks is at least 3
// Notes: clr holds the phase at zero so a profile starts on a full ms
`timescale 1ns/1ps
`default_nettype none

module lut_ms_tick #(
    parameter int unsigned TICKS = 25000
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control and pulse
    input wire logic clr,
    output logic tick
);

    logic [31:0] cnt_q;
    logic tick_q;

    wire wrap = cnt_q == 32'(TICKS - 1);

    // free count, restarted by clr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 32'h0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= (clr || wrap) ? 32'h0 : cnt_q + 32'h1;
            tick_q <= !clr && wrap;
        end
    end

    assign tick = tick_q;

    a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        tick_q |=> !tick_q [*2])
        else $error("ms ticks too close");

endmodule : lut_ms_tick
`default_nettype wire

// >>> hdl/lut_response.sv
// Purpose: eleven-point lookup table, data or time response, apb setup
// Assumes: ctrl_value comes from logic on pclk
// Notes: ramp points take about fifty cycles to settle
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "lut_cfg.svh"

module lut_response #(
    parameter int unsigned TICK_CYCLES = `LUT_TICK_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // control source
    input wire logic [31:0] ctrl_value,
    // table output
    output logic signed [15:0] table_out,
    output lut_pkg::lut_limits_type out_limits,
    output logic profile_active,
    output logic profile_done
);

    // point storage
    logic signed [31:0] x_q [0:10];
    logic signed [15:0] y_q [0:10];
    lut_pkg::lut_resp_type resp_q [0:10];
    logic [1:0] ctrl_q;
    logic signed [31:0] thresh_q;

    // bus answer
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    // evaluation and profile state
    lut_pkg::lut_state_type st_q;
    logic signed [15:0] out_q;
    logic signed [15:0] base_q;
    logic neg_q;
    lut_pkg::lut_limits_type lim_q;
    lut_pkg::lut_limits_type lim_c;
    logic [3:0] tseg_q;
    logic [31:0] tcnt_q;
    logic done_q;
    logic on_q;
    logic active_q;
    logic [3:0] last_c;
    logic [3:0] dseg_c;
    logic [31:0] rd_c;

    // apb decode
    wire [1:0] region = paddr[7:6];
    wire [3:0] pidx = paddr[5:2];
    wire hi_zero = paddr[11:8] == 4'h0 && paddr[1:0] == 2'h0;
    wire idx_ok = pidx <= `LUT_LAST;
    wire misc_ok = pidx <= `LUT_ADDR_THRESH;
    wire mapped = hi_zero && (region == 2'h0 ? misc_ok : idx_ok);
    wire setup = psel && !penable;
    wire wr_en = psel && penable && pwrite && pready_q && !pslverr_q;
    wire wr_misc = wr_en && region == 2'h0;
    wire wr_x = wr_en && region == `LUT_REG_X;
    wire wr_y = wr_en && region == `LUT_REG_Y;
    wire wr_resp = wr_en && region == `LUT_REG_RESP && pidx != 4'h0;
    wire [1:0] resp_wr = pwdata[1:0] == 2'h3 ? 2'h0 : pwdata[1:0];

    // mode and control source conversion
    wire time_mode = ctrl_q[`LUT_CTRL_TIME];
    wire digital = ctrl_q[`LUT_CTRL_DIGITAL];
    wire nonzero = ctrl_value != 32'h0;
    wire signed [31:0] x_in = digital ? {31'h0, nonzero} : ctrl_value;
    wire ctrl_on = digital ? nonzero : $signed(ctrl_value) >= thresh_q;
    wire run = time_mode && ctrl_on;

    // segment selection, shared by both modes
    wire [3:0] seg = time_mode ? tseg_q : dseg_c;
    wire [3:0] seg_m1 = seg == 4'h0 ? 4'h0 : seg - 4'h1;
    wire signed [15:0] y_a = y_q[seg_m1];
    wire signed [15:0] y_b = y_q[seg];
    wire signed [15:0] y_last = y_q[last_c];
    wire signed [31:0] x_a = x_q[seg_m1];
    wire signed [31:0] x_b = x_q[seg];

    // interval and offset; time intervals below 1 ms act as 1 ms
    wire [31:0] ival = x_b == 32'h0 ? 32'h1 : x_b;
    wire [32:0] dspan = 33'({x_b[31], x_b} - {x_a[31], x_a});
    wire [32:0] doff = 33'({x_in[31], x_in} - {x_a[31], x_a});
    wire [32:0] span = time_mode ? {1'b0, ival} : dspan;
    wire [32:0] off_raw = time_mode ? {1'b0, tcnt_q} : doff;
    wire [32:0] off = off_raw > span ? span : off_raw;
    wire signed [16:0] dy = {y_b[15], y_b} - {y_a[15], y_a};
    wire [15:0] dy_mag = dy[16] ? 16'(-dy) : dy[15:0];

    // cases answered without a divide
    wire t_off = time_mode && !ctrl_on;
    wire t_done = time_mode && done_q;
    wire d_below = !time_mode && x_in <= x_q[0];
    wire d_above = !time_mode && x_in > x_q[last_c];
    wire is_step = resp_q[seg] == lut_pkg::lut_step;
    wire flat = span == 33'h0 || span[32] || off == 33'h0 || dy == 17'h0;
    wire direct = t_off || t_done || d_below || d_above || is_step || flat;
    wire need_div = !direct;
    wire div_start = need_div && st_q == lut_pkg::lut_idle;

    // direct value, highest priority first
    wire signed [15:0] dir_val = t_off ? 16'sh0000 :
        (t_done || d_above) ? y_last :
        d_below ? y_q[0] :
        (is_step || span == 33'h0) ? y_b :
        off == 33'h0 ? y_a : y_b;

    // divider hookup
    lut_pkg::lut_div_req_type div_req;
    logic div_done;
    logic [15:0] div_quo;
    assign div_req.num = 49'(dy_mag) * 49'(off);
    assign div_req.den = span;
    wire signed [16:0] q_s = neg_q ? -17'(div_quo) : 17'(div_quo);
    wire signed [16:0] ramp_sum = {base_q[15], base_q} + q_s;

    lut_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .start(div_start),
        .req(div_req),
        .done(div_done),
        .quo(div_quo)
    );

    // ms base held at phase zero whenever the profile is not running
    logic tick;
    lut_ms_tick #(.TICKS(TICK_CYCLES)) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .clr(!run),
        .tick(tick)
    );

    // active length, data segment and y limits
    always_comb begin
        last_c = `LUT_LAST;
        for (int i = 10; i >= 1; i--) begin
            if (resp_q[i] == lut_pkg::lut_ignore) last_c = 4'(i - 1);
        end
        dseg_c = last_c;
        for (int i = 10; i >= 1; i--) begin
            if (i <= int'(last_c) && x_in <= x_q[i]) dseg_c = 4'(i);
        end
        lim_c.hi = y_q[0];
        lim_c.lo = y_q[0];
        for (int i = 1; i <= 10; i++) begin
            if (i <= int'(last_c) && y_q[i] > lim_c.hi) lim_c.hi = y_q[i];
            if (i <= int'(last_c) && y_q[i] < lim_c.lo) lim_c.lo = y_q[i];
        end
    end

    // read mux; reserved bits read zero
    always_comb begin
        rd_c = 32'h0;
        case (region)
            2'h0: begin
                case (pidx)
                    `LUT_ADDR_CTRL: rd_c = {30'h0, ctrl_q};
                    `LUT_ADDR_STATUS: rd_c = {24'h0, last_c, 1'b0, done_q, active_q, on_q};
                    `LUT_ADDR_OUT: rd_c = {{16{out_q[15]}}, out_q};
                    `LUT_ADDR_LIMITS: rd_c = lim_q;
                    `LUT_ADDR_THRESH: rd_c = thresh_q;
                    default: rd_c = 32'h0;
                endcase
            end
            `LUT_REG_X: rd_c = idx_ok ? x_q[pidx] : 32'h0;
            `LUT_REG_Y: rd_c = idx_ok ? {{16{y_q[pidx][15]}}, y_q[pidx]} : 32'h0;
            `LUT_REG_RESP: rd_c = idx_ok ? {30'h0, resp_q[pidx]} : 32'h0;
            default: rd_c = 32'h0;
        endcase
    end

    // apb answer: ready in the first access cycle, error on unmapped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && !mapped;
            prdata_q <= (setup && !pwrite && mapped) ? rd_c : 32'h0;
        end
    end

    // misc control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `LUT_CTRL_RST;
            thresh_q <= `LUT_THRESH_RST;
        end else if (wr_misc && pidx == `LUT_ADDR_CTRL) begin
            ctrl_q <= pwdata[1:0];
        end else if (wr_misc && pidx == `LUT_ADDR_THRESH) begin
            thresh_q <= pwdata;
        end
    end

    // point table; point zero response is fixed ramp
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i <= 10; i++) begin
                x_q[i] <= 32'(i);
                y_q[i] <= 16'(i);
                resp_q[i] <= lut_pkg::lut_ramp;
            end
        end else begin
            if (wr_x && idx_ok) x_q[pidx] <= pwdata;
            if (wr_y && idx_ok) y_q[pidx] <= pwdata[15:0];
            if (wr_resp && idx_ok) resp_q[pidx] <= lut_pkg::lut_resp_type'(resp_wr);
        end
    end

    // time profile walker; off state doubles as the restart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tseg_q <= 4'h1;
            tcnt_q <= 32'h0;
            done_q <= 1'b0;
        end else if (!run) begin
            tseg_q <= 4'h1;
            tcnt_q <= 32'h0;
            done_q <= last_c == 4'h0;
        end else if (tick && !done_q) begin
            if (tcnt_q + 32'h1 >= ival) begin
                if (tseg_q >= last_c) begin
                    done_q <= 1'b1;
                end else begin
                    tseg_q <= tseg_q + 4'h1;
                    tcnt_q <= 32'h0;
                end
            end else begin
                tcnt_q <= tcnt_q + 32'h1;
            end
        end
    end

    // evaluation: direct answers land next cycle, ramps after a divide
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= lut_pkg::lut_idle;
            out_q <= 16'sh0000;
            base_q <= 16'sh0000;
            neg_q <= 1'b0;
        end else begin
            case (st_q)
                lut_pkg::lut_idle: begin
                    if (need_div) begin
                        base_q <= y_a;
                        neg_q <= dy[16];
                        st_q <= lut_pkg::lut_wait;
                    end else begin
                        out_q <= dir_val;
                    end
                end
                lut_pkg::lut_wait: begin
                    if (!need_div) begin
                        out_q <= dir_val;
                        st_q <= lut_pkg::lut_idle;
                    end else if (div_done) begin
                        out_q <= ramp_sum[15:0];
                        st_q <= lut_pkg::lut_idle;
                    end
                end
                default: st_q <= lut_pkg::lut_idle;
            endcase
        end
    end

    // status and limit flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_q <= 1'b0;
            active_q <= 1'b0;
            lim_q <= 32'h0;
        end else begin
            on_q <= ctrl_on;
            active_q <= run && !done_q;
            lim_q <= lim_c;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign table_out = out_q;
    assign out_limits = lim_q;
    assign profile_active = active_q;
    assign profile_done = done_q;

    a_time_off_zero: assert property (@(posedge pclk) disable iff (!presetn)
        t_off |=> out_q == 16'sh0000)
        else $error("time mode output not zero while off");

    a_step_exact: assert property (@(posedge pclk) disable iff (!presetn)
        (!time_mode && is_step && !d_below && !d_above) |=> out_q == $past(y_b))
        else $error("step output differs from point y");

    a_above_hold: assert property (@(posedge pclk) disable iff (!presetn)
        d_above |=> out_q == $past(y_last))
        else $error("output above last active x wrong");

    a_done_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (t_done && ctrl_on) |=> out_q == $past(y_last))
        else $error("finished profile not holding last y");

    a_restart_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (time_mode && !on_q && ctrl_on) |-> tseg_q == 4'h1 && tcnt_q == 32'h0)
        else $error("profile did not restart at point zero");

    // the edge right after reset release still shows the cleared limits, so it is skipped
    a_limits_track: assert property (@(posedge pclk) disable iff (!presetn)
        $past(presetn) |-> lim_q == $past(lim_c) && lim_q.lo <= lim_q.hi)
        else $error("output limits wrong");

    a_ignore_trunc: assert property (@(posedge pclk) disable iff (!presetn)
        last_c < `LUT_LAST |-> resp_q[last_c + 4'h1] == lut_pkg::lut_ignore)
        else $error("active length ignores an ignored point");

    a_ival_floor: assert property (@(posedge pclk) disable iff (!presetn)
        time_mode |-> ival != 32'h0 && off <= span)
        else $error("time interval below 1 ms");

    a_digital_x: assert property (@(posedge pclk) disable iff (!presetn)
        digital |-> x_in == 32'h0 || x_in == 32'h1)
        else $error("digital source not zero or one");

    a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready_q ##1 !pready_q)
        else $error("apb ready not a single access cycle");

endmodule : lut_response
`default_nettype wire

// >>> bench/lut_ctrl_src.sv
// Purpose: upstream control source model driving ctrl_value, downstream output model
// Assumes: same clock as the table, changes land just after a rising edge
// Notes: lag delays each new value, so slow sources are exercised as well
`timescale 1ns/1ps
`default_nettype none

module lut_ctrl_src (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request from the bench
    input wire logic [31:0] want,
    input wire logic [3:0] lag,
    // control source output
    output logic [31:0] ctrl_value
);
    logic [3:0] cnt_q;

    // a new value lands only after lag edges, like a message arriving late
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
            ctrl_value <= 32'h00000000;
        end else if (want == ctrl_value) begin
            cnt_q <= 4'h0;
        end else if (cnt_q >= lag) begin
            cnt_q <= 4'h0;
            ctrl_value <= want;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule : lut_ctrl_src

module lut_out_sink (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // table output and slew settings of the driven block, zero means no limit
    input wire logic signed [15:0] table_out,
    input wire logic [15:0] output_rise_rate,
    input wire logic [15:0] output_fall_rate,
    // value the driven output block applies
    output logic signed [15:0] drive
);
    wire signed [16:0] diff = {table_out[15], table_out} - {drive[15], drive};
    wire signed [16:0] up = {1'b0, output_rise_rate};
    wire signed [16:0] dn = {1'b0, output_fall_rate};
    wire up_lim = output_rise_rate != 16'h0000 && diff > up;
    wire dn_lim = output_fall_rate != 16'h0000 && -diff > dn;

    // a nonzero rate bends a timed profile out of shape, so time tables need zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive <= 16'sh0000;
        end else if (up_lim) begin
            drive <= drive + output_rise_rate;
        end else if (dn_lim) begin
            drive <= drive - output_fall_rate;
        end else begin
            drive <= table_out;
        end
    end
endmodule : lut_out_sink
`default_nettype wire

// >>> bench/tb_lut_response.sv
// Purpose: self-checking bench for the lookup table over apb
// Assumes: one-cycle apb answer, 1 ms shortened to TICKS cycles
// Notes: table output is polled under a bound, ramps settle slowly
`timescale 1ns/1ps
`default_nettype none

module tb_lut_response;
    localparam int unsigned TICKS = 100;
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_STAT = 12'h004;
    localparam logic [11:0] A_LIM = 12'h00C;
    localparam logic [11:0] A_THR = 12'h010;
    localparam logic [11:0] A_X = 12'h040;
    localparam logic [11:0] A_Y = 12'h080;
    localparam logic [11:0] A_R = 12'h0C0;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] want = 32'h00000000;
    logic [3:0] lag = 4'h0;
    logic [31:0] ctrl_value;
    logic signed [15:0] table_out;
    lut_pkg::lut_limits_type out_limits;
    logic profile_active;
    logic profile_done;
    logic signed [15:0] drive;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int compares = 0;

    // 25 MHz clock
    always #20 pclk = ~pclk;

    lut_response #(.TICK_CYCLES(TICKS)) u_lut_response (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ctrl_value(ctrl_value), .table_out(table_out), .out_limits(out_limits),
        .profile_active(profile_active), .profile_done(profile_done));

    lut_ctrl_src u_lut_ctrl_src (.pclk(pclk), .presetn(presetn), .want(want), .lag(lag),
        .ctrl_value(ctrl_value));

    lut_out_sink u_lut_out_sink (.pclk(pclk), .presetn(presetn), .table_out(table_out),
        .output_rise_rate(16'h0000), .output_fall_rate(16'h0000), .drive(drive));

    // verdict and the single exit of the run
    task automatic end_sim;
        if (n_mismatch == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            chk({31'h0, pready}, 32'h1);
            end_sim();
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask : rd_chk

    task automatic src(input logic [31:0] v);
        @(posedge pclk);
        want <= v;
    endtask : src

    // bounded poll; ramps need about fifty cycles to appear
    task automatic wait_out(input logic [15:0] exp);
        int n;
        n = 0;
        while (table_out !== exp && n < 800) begin
            @(posedge pclk);
            n++;
        end
        chk({16'h0000, table_out}, {16'h0000, exp});
        if (n >= 800) begin
            end_sim();
        end
    endtask : wait_out

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // reset contents
        rd_chk(A_CTRL, 32'h00000000);
        rd_chk(A_THR, 32'h00000001);
        rd_chk(A_X + 12'h00C, 32'h00000003);
        rd_chk(A_Y + 12'h028, 32'h0000000A);
        rd_chk(A_R + 12'h010, 32'h00000001);
        chk(out_limits, 32'h000A0000);
        // point zero keeps ramp; code 3 is stored as ignore and then undone
        wr(A_R, 32'h00000000);
        rd_chk(A_R, 32'h00000001);
        wr(A_R + 12'h028, 32'h00000003);
        rd_chk(A_R + 12'h028, 32'h00000000);
        wr(A_R + 12'h028, 32'h00000001);
        // unmapped places answer with an error and zero data
        apb(1'b0, 12'h06C, 32'h00000000);
        chk({31'h0, err}, 32'h00000001);
        chk(rd, 32'h00000000);
        apb(1'b1, 12'h100, 32'h00000055);
        chk({31'h0, err}, 32'h00000001);
        // x falls from the top so the axis never goes backwards
        for (int i = 10; i >= 1; i--) begin
            wr(A_X + 12'(4 * i), 32'(10 * i));
            wr(A_Y + 12'(4 * i), 32'(100 * i));
        end
        lag <= 4'h3;
        src(32'd25);
        wait_out(16'd250);
        wr(A_R + 12'h00C, 32'h00000002);
        wait_out(16'd300);
        src(32'd55);
        wait_out(16'd550);
        wr(A_R + 12'h014, 32'h00000000);
        wait_out(16'd400);
        chk(out_limits, 32'h01900000);
        rd_chk(A_LIM, 32'h01900000);
        // digital source sees only zero or one
        wr(A_CTRL, 32'h00000002);
        src(32'd7);
        wait_out(16'd10);
        wr(A_X + 12'h004, 32'h05265C00);
        rd_chk(A_X + 12'h004, 32'h05265C00);
        // time profile: 2 ms interpolate_segment 100, 1 ms step to 200, then ignored
        // source goes off first and settles during the writes, so no stray run appears
        src(32'hFFFFFFFD);
        wr(A_X + 12'h004, 32'h00000002);
        wr(A_X + 12'h008, 32'h00000001);
        wr(A_R + 12'h008, 32'h00000002);
        wr(A_R + 12'h00C, 32'h00000000);
        wr(A_CTRL, 32'h00000001);
        wait_out(16'd0);
        chk({31'h0, profile_active}, 32'h00000000);
        src(32'd5);
        wait_out(16'd50);
        wait_out(16'd200);
        repeat (300) @(posedge pclk);
        chk({31'h0, profile_done}, 32'h00000001);
        chk({16'h0000, table_out}, 32'h000000C8);
        chk({16'h0000, drive}, 32'h000000C8);
        rd_chk(A_STAT, 32'h00000025);
        chk(out_limits, 32'h00C80000);
        src(32'd0);
        wait_out(16'd0);
        // on at exactly the threshold restarts from point zero
        src(32'd1);
        for (int n = 0; n < 50 && profile_active !== 1'b1; n++) begin
            @(posedge pclk);
        end
        chk({31'h0, profile_active}, 32'h00000001);
        chk({16'h0000, table_out}, 32'h00000000);
        wait_out(16'd50);
        end_sim();
    end
endmodule : tb_lut_response
`default_nettype wire
